// ---- inc/vfr_defines.svh ----
// command codes, field positions, reset values and timing figures of the vout fault block
`ifndef VFR_DEFINES_SVH
`define VFR_DEFINES_SVH

`define VFR_NUM_RAILS      2
`define VFR_PAGE_W         1

`define VFR_CMD_OV_LIMIT   8'h40
`define VFR_CMD_OV_RSP     8'h41
`define VFR_CMD_UV_LIMIT   8'h44
`define VFR_CMD_UV_RSP     8'h45

`define VFR_RSP_RESET      8'h80
`define VFR_RSP_SHUT_BIT   7
`define VFR_RSP_RETRY_HI   5
`define VFR_RSP_RETRY_LO   3
`define VFR_RSP_DELAY_HI   2
`define VFR_RSP_DELAY_LO   0
`define VFR_RETRY_NONE     3'h0
`define VFR_RETRY_CONT     3'h7

// default limits as ratio of the strapped setpoint: 1.10 and 0.85
`define VFR_OV_DEF_NUM     5'h0b
`define VFR_OV_DEF_DEN     5'h0a
`define VFR_UV_DEF_NUM     5'h11
`define VFR_UV_DEF_DEN     5'h14

`define VFR_RETRY_UNIT_MS  35
`define VFR_CLK_KHZ        40000
`define VFR_RETRY_UNIT_CYC (`VFR_RETRY_UNIT_MS * `VFR_CLK_KHZ)

`endif

// ---- inc/vfr_pkg.sv ----
// types of the vout fault block
package vfr_pkg;
`include "vfr_defines.svh"

    typedef enum logic [1:0] {
        VFR_RUN,
        VFR_LATCH,
        VFR_WAIT,
        VFR_TRY
    } vfr_state_e_t;

    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [`VFR_PAGE_W-1:0] page;
        logic [7:0]             code;
        logic [15:0]            wdata;
    } vfr_cmd_t;

    typedef struct packed {
        vfr_state_e_t st;
        logic [15:0]  ov_lim;
        logic [15:0]  uv_lim;
        logic [7:0]   ov_rsp;
        logic [7:0]   uv_rsp;
        logic [2:0]   dly;
        logic [31:0]  timer;
        logic         ov_flag;
        logic         uv_flag;
    } vfr_rail_t;

    typedef struct packed {
        vfr_rail_t [`VFR_NUM_RAILS-1:0] rail;
        logic [`VFR_NUM_RAILS-1:0]      en;
        logic                           alert;
        logic [15:0]                    rdata;
    } vfr_st_t;

endpackage

// ---- logic/vfr_top.sv ----
// output overvoltage / undervoltage fault supervision, one set of settings per rail page
`timescale 1ns/10ps
`include "vfr_defines.svh"
module vfr_top
    import vfr_pkg::*;
#(
    parameter int unsigned RETRY_UNIT_CYC = `VFR_RETRY_UNIT_CYC
) (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         srst,
    // command port from the management bus engine
    input  wire vfr_cmd_t                     cmd,
    input  wire logic                         clear_faults,
    output logic      [15:0]                  cmd_rdata,
    // per rail inputs
    input  wire logic [`VFR_NUM_RAILS-1:0][15:0] setpoint_strap,
    input  wire logic [`VFR_NUM_RAILS-1:0][15:0] vout_meas,
    input  wire logic [`VFR_NUM_RAILS-1:0]    meas_valid,
    input  wire logic [`VFR_NUM_RAILS-1:0]    power_good_flag,
    input  wire logic [`VFR_NUM_RAILS-1:0]    ramping,
    input  wire logic [`VFR_NUM_RAILS-1:0]    rail_on_req,
    input  wire logic [`VFR_NUM_RAILS-1:0]    bias_ok,
    input  wire logic [`VFR_NUM_RAILS-1:0]    other_shutdown,
    // per rail outputs
    output logic      [`VFR_NUM_RAILS-1:0]    rail_enable,
    output logic      [`VFR_NUM_RAILS-1:0]    ov_fault,
    output logic      [`VFR_NUM_RAILS-1:0]    uv_fault,
    // open-drain alert line
    output logic                              alert_line_o,
    output logic                              alert_line_oe
);

    localparam int NR = `VFR_NUM_RAILS;

    vfr_st_t state_ff;
    vfr_st_t nxt_state;

    // ratio scaling of the strap, saturating so a high strap cannot wrap to a low limit
    function automatic logic [15:0] scale_strap(input logic [15:0] v,
                                                input logic [4:0]  num,
                                                input logic [4:0]  den);
        logic [20:0] p;
        p = (21'(v) * 21'(num)) / 21'(den);
        return (p[20:16] != 5'h00) ? 16'hffff : p[15:0];
    endfunction

    function automatic logic [31:0] retry_cycles(input logic [2:0] d);
        return 32'((32'(d) + 32'h1) * RETRY_UNIT_CYC);
    endfunction

    function automatic logic [15:0] read_mux(input vfr_rail_t r, input logic [7:0] code);
        logic [15:0] v;
        v = 16'h0000;
        case (code)
            `VFR_CMD_OV_LIMIT: v = r.ov_lim;
            `VFR_CMD_OV_RSP:   v = {8'h00, r.ov_rsp};
            `VFR_CMD_UV_LIMIT: v = r.uv_lim;
            `VFR_CMD_UV_RSP:   v = {8'h00, r.uv_rsp};
            default:           v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic logic shuts(input logic [7:0] rsp);
        return rsp[`VFR_RSP_SHUT_BIT];
    endfunction

    function automatic logic cont_retry(input logic [7:0] rsp);
        return rsp[`VFR_RSP_RETRY_HI:`VFR_RSP_RETRY_LO] == `VFR_RETRY_CONT;
    endfunction

    always_comb begin
        vfr_rail_t r;
        logic      ov_hit;
        logic      uv_hit;
        logic      shut;
        logic      cont;
        logic [2:0] dly;
        logic      off_cmd;
        r         = '0;
        ov_hit    = 1'b0;
        uv_hit    = 1'b0;
        shut      = 1'b0;
        cont      = 1'b0;
        dly       = 3'h0;
        off_cmd   = 1'b0;
        nxt_state = state_ff;
        if (srst) begin
            nxt_state = '0;
            for (int i = 0; i < NR; i++) begin
                nxt_state.rail[i].st     = VFR_RUN;
                nxt_state.rail[i].ov_lim = scale_strap(setpoint_strap[i],
                    `VFR_OV_DEF_NUM, `VFR_OV_DEF_DEN);
                nxt_state.rail[i].uv_lim = scale_strap(setpoint_strap[i],
                    `VFR_UV_DEF_NUM, `VFR_UV_DEF_DEN);
                nxt_state.rail[i].ov_rsp = `VFR_RSP_RESET;
                nxt_state.rail[i].uv_rsp = `VFR_RSP_RESET;
            end
        end else begin
            if (cmd.valid && !cmd.write) begin
                nxt_state.rdata = 16'h0000;
                for (int i = 0; i < NR; i++) begin
                    if (cmd.page == `VFR_PAGE_W'(i)) begin
                        nxt_state.rdata = read_mux(state_ff.rail[i], cmd.code);
                    end
                end
            end
            for (int i = 0; i < NR; i++) begin
                r = state_ff.rail[i];
                // settings land only in the addressed page
                if (cmd.valid && cmd.write && cmd.page == `VFR_PAGE_W'(i)) begin
                    case (cmd.code)
                        `VFR_CMD_OV_LIMIT: r.ov_lim = cmd.wdata;
                        `VFR_CMD_OV_RSP:   r.ov_rsp = cmd.wdata[7:0];
                        `VFR_CMD_UV_LIMIT: r.uv_lim = cmd.wdata;
                        `VFR_CMD_UV_RSP:   r.uv_rsp = cmd.wdata[7:0];
                        default: ;
                    endcase
                end
                // comparisons use the limits in force before this cycle's write
                ov_hit = meas_valid[i] && (vout_meas[i] > state_ff.rail[i].ov_lim);
                uv_hit = meas_valid[i] && power_good_flag[i] && rail_on_req[i]
                         && !ramping[i] && (state_ff.rail[i].st == VFR_RUN)
                         && (vout_meas[i] < state_ff.rail[i].uv_lim);
                // set wins over a clear in the same cycle
                if (clear_faults) begin
                    r.ov_flag = 1'b0;
                    r.uv_flag = 1'b0;
                end
                if (ov_hit) begin
                    r.ov_flag = 1'b1;
                end
                if (uv_hit) begin
                    r.uv_flag = 1'b1;
                end
                // overvoltage retry and delay settings take precedence when both trip together; either response's bit 7 shuts down
                shut = (ov_hit && shuts(state_ff.rail[i].ov_rsp))
                       || (uv_hit && shuts(state_ff.rail[i].uv_rsp));
                cont = ov_hit ? cont_retry(state_ff.rail[i].ov_rsp)
                              : cont_retry(state_ff.rail[i].uv_rsp);
                dly  = ov_hit ? state_ff.rail[i].ov_rsp[`VFR_RSP_DELAY_HI:`VFR_RSP_DELAY_LO]
                              : state_ff.rail[i].uv_rsp[`VFR_RSP_DELAY_HI:`VFR_RSP_DELAY_LO];
                off_cmd = !rail_on_req[i] || !bias_ok[i];
                if (r.timer != 32'h0) begin
                    r.timer = r.timer - 32'h1;
                end
                unique case (state_ff.rail[i].st)
                    VFR_RUN: begin
                        if (shut && cont) begin
                            r.st    = VFR_WAIT;
                            r.dly   = dly;
                            r.timer = retry_cycles(dly) - 32'h1;
                        end else if (shut) begin
                            // unused retry codes behave as no retry
                            r.st = VFR_LATCH;
                        end
                    end
                    VFR_LATCH: begin
                        r.st = VFR_LATCH;
                    end
                    VFR_WAIT: begin
                        if (off_cmd) begin
                            r.st = VFR_RUN;
                        end else if (other_shutdown[i]) begin
                            r.st = VFR_LATCH;
                        end else if (state_ff.rail[i].timer == 32'h0) begin
                            r.st    = VFR_TRY;
                            r.timer = retry_cycles(state_ff.rail[i].dly) - 32'h1;
                        end
                    end
                    VFR_TRY: begin
                        if (off_cmd) begin
                            r.st = VFR_RUN;
                        end else if (other_shutdown[i]) begin
                            r.st = VFR_LATCH;
                        end else if (shut) begin
                            // next attempt counted from this attempt's start
                            r.st = VFR_WAIT;
                        end else if (power_good_flag[i]) begin
                            r.st    = VFR_RUN;
                            r.timer = 32'h0;
                        end
                    end
                endcase
                nxt_state.rail[i] = r;
            end
        end
        nxt_state.alert = 1'b0;
        for (int i = 0; i < NR; i++) begin
            nxt_state.alert = nxt_state.alert | nxt_state.rail[i].ov_flag
                              | nxt_state.rail[i].uv_flag;
            // enable comes from a flop so the pin never sees a state decode glitch
            nxt_state.en[i] = (nxt_state.rail[i].st == VFR_RUN)
                              || (nxt_state.rail[i].st == VFR_TRY);
        end
    end

    always_ff @(posedge core_clk) begin
        state_ff <= nxt_state;
    end

    assign cmd_rdata     = state_ff.rdata;
    assign alert_line_o  = 1'b0;
    assign alert_line_oe = state_ff.alert;

    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_out
            assign rail_enable[g] = state_ff.en[g];
            assign ov_fault[g]    = state_ff.rail[g].ov_flag;
            assign uv_fault[g]    = state_ff.rail[g].uv_flag;
        end
    endgenerate

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    generate
        for (g = 0; g < NR; g++) begin : g_chk
            ov_detect_a: assert property (
                meas_valid[g] && vout_meas[g] > state_ff.rail[g].ov_lim
                |=> ov_fault[g] && alert_line_oe)
                else $error("overvoltage not flagged");
            uv_mask_a: assert property (
                $rose(uv_fault[g]) |-> $past(power_good_flag[g]) && !$past(ramping[g])
                && $past(rail_on_req[g]))
                else $error("undervoltage flagged while masked");
            flag_sticky_a: assert property (
                ov_fault[g] && !clear_faults |=> ov_fault[g])
                else $error("fault bit dropped without clear");
            rsp_reset_a: assert property (
                $fell(srst) |-> state_ff.rail[g].ov_rsp == `VFR_RSP_RESET
                && state_ff.rail[g].uv_rsp == `VFR_RSP_RESET)
                else $error("response default wrong");
            lim_default_a: assert property (
                $fell(srst) |-> state_ff.rail[g].ov_lim == scale_strap($past(setpoint_strap[g]),
                `VFR_OV_DEF_NUM, `VFR_OV_DEF_DEN))
                else $error("overvoltage default wrong");
            uv_default_a: assert property (
                $fell(srst) |-> state_ff.rail[g].uv_lim == scale_strap($past(setpoint_strap[g]),
                `VFR_UV_DEF_NUM, `VFR_UV_DEF_DEN))
                else $error("undervoltage default wrong");
            lim_write_a: assert property (
                cmd.valid && cmd.write && cmd.page == `VFR_PAGE_W'(g)
                && cmd.code == `VFR_CMD_UV_LIMIT
                |=> state_ff.rail[g].uv_lim == $past(cmd.wdata))
                else $error("limit write lost");
            page_sep_a: assert property (
                cmd.valid && cmd.write && cmd.page != `VFR_PAGE_W'(g)
                |=> $stable(state_ff.rail[g].ov_lim) && $stable(state_ff.rail[g].ov_rsp))
                else $error("write leaked to other page");
            shut_off_a: assert property (
                rail_enable[g] && state_ff.rail[g].st == VFR_RUN && meas_valid[g]
                && vout_meas[g] > state_ff.rail[g].ov_lim && state_ff.rail[g].ov_rsp[7]
                |=> !rail_enable[g])
                else $error("no shutdown on fault");
            latch_hold_a: assert property (
                state_ff.rail[g].st == VFR_LATCH |=> !rail_enable[g] [*3])
                else $error("latched rail restarted");
            retry_go_a: assert property (
                state_ff.rail[g].st == VFR_WAIT && state_ff.rail[g].timer == 32'h0
                && rail_on_req[g] && bias_ok[g] && !other_shutdown[g]
                |=> rail_enable[g] && state_ff.rail[g].timer
                == retry_cycles(state_ff.rail[g].dly) - 32'h1)
                else $error("retry attempt not started");
            retry_stop_a: assert property (
                state_ff.rail[g].st == VFR_WAIT && !rail_on_req[g]
                |=> state_ff.rail[g].st == VFR_RUN)
                else $error("retry not ended by off command");
            uv_detect_a: assert property (
                meas_valid[g] && power_good_flag[g] && rail_on_req[g] && !ramping[g]
                && state_ff.rail[g].st == VFR_RUN && vout_meas[g] < state_ff.rail[g].uv_lim
                |=> uv_fault[g] && alert_line_oe)
                else $error("undervoltage not flagged");
            clear_drop_a: assert property (
                clear_faults && !(meas_valid[g] && vout_meas[g] > state_ff.rail[g].ov_lim)
                |=> !ov_fault[g])
                else $error("fault bit kept after clear");
            flag_only_a: assert property (
                state_ff.rail[g].st == VFR_RUN && meas_valid[g]
                && vout_meas[g] > state_ff.rail[g].ov_lim && !state_ff.rail[g].ov_rsp[7]
                && vout_meas[g] >= state_ff.rail[g].uv_lim
                |=> rail_enable[g] && ov_fault[g])
                else $error("shutdown with response bit 7 clear");
            other_latch_a: assert property (
                state_ff.rail[g].st == VFR_WAIT && rail_on_req[g] && bias_ok[g]
                && other_shutdown[g]
                |=> state_ff.rail[g].st == VFR_LATCH && !rail_enable[g])
                else $error("retry not ended by other fault");
            bias_stop_a: assert property (
                state_ff.rail[g].st == VFR_WAIT && !bias_ok[g]
                |=> state_ff.rail[g].st == VFR_RUN && rail_enable[g])
                else $error("retry not ended by bias loss");
        end
    endgenerate

endmodule

// ---- testbench/vfr_host_model.sv ----
// host model driving the fault block command port
`timescale 1ns/10ps
`include "vfr_defines.svh"
module vfr_host_model
    import vfr_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // command port
    output vfr_cmd_t  cmd
);
    initial cmd = '0;

    // launch after a falling edge, hold over the taking edge, then release
    task automatic issue(input logic w, input logic p, input logic [7:0] c,
                         input logic [15:0] d);
        @(negedge core_clk);
        cmd = '{1'b1, w, p, c, d};
        @(negedge core_clk);
        cmd = '{1'b0, 1'b0, ~p, ~c, ~d};
    endtask

    // uv limit kept under the power good level, response parked at plain shutdown
    task automatic set_uv_safe(input logic p, input logic [15:0] lim,
                               input logic [15:0] pg_lvl);
        issue(1'b1, p, `VFR_CMD_UV_LIMIT, (lim < pg_lvl) ? lim : pg_lvl - 16'h1);
        issue(1'b1, p, `VFR_CMD_UV_RSP, {8'h0, `VFR_RSP_RESET});
    endtask
endmodule

// ---- testbench/vfr_top_test.sv ----
// self-checking bench of the vout fault block
`timescale 1ns/10ps
`include "vfr_defines.svh"
module vfr_top_test
    import vfr_pkg::*;
;
    localparam int unsigned UNIT = 8;
    logic                            core_clk = 1'b0;
    logic                            srst, clear_faults, samp;
    vfr_cmd_t                        h_cmd;
    logic [15:0]                     cmd_rdata;
    logic [`VFR_NUM_RAILS-1:0][15:0] strap, meas;
    logic [`VFR_NUM_RAILS-1:0]       mv, pgf, ramp, on_req, bias, oth;
    logic [`VFR_NUM_RAILS-1:0]       rail_enable, ov_fault, uv_fault;
    logic                            alert_o, alert_oe;
    logic [6:0]                      status;
    logic [15:0]                     rd_q[$], st_q[$], lo[2];
    logic                            rd_now, st_now;
    int                              fail_count = 0, num_checks = 0, cyc = 0, n;
    logic [2:0]                      d;

    assign status = {rail_enable, ov_fault, uv_fault, alert_oe};
    always #12.5 core_clk = ~core_clk;

    vfr_host_model vfr_host_model_i (.core_clk(core_clk), .cmd(h_cmd));
    vfr_top #(.RETRY_UNIT_CYC(UNIT)) vfr_top_i (
        .core_clk(core_clk), .srst(srst), .cmd(h_cmd), .clear_faults(clear_faults),
        .cmd_rdata(cmd_rdata), .setpoint_strap(strap), .vout_meas(meas),
        .meas_valid(mv), .power_good_flag(pgf), .ramping(ramp), .rail_on_req(on_req),
        .bias_ok(bias), .other_shutdown(oth), .rail_enable(rail_enable),
        .ov_fault(ov_fault), .uv_fault(uv_fault), .alert_line_o(alert_o),
        .alert_line_oe(alert_oe));

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        num_checks++;
        if (act !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask

    // watcher: read data and status samples are compared after the edge settles
    always @(posedge core_clk) begin
        rd_now = h_cmd.valid && !h_cmd.write && !srst;
        st_now = samp;
        #2;
        if (rd_now) chk(cmd_rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 16'hdead);
        if (st_now) chk({9'h0, status}, (st_q.size() > 0) ? st_q.pop_front() : 16'hdead);
    end

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] v);
        vfr_host_model_i.issue(1'b1, p, c, v);
    endtask

    task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e);
        rd_q.push_back(e);
        vfr_host_model_i.issue(1'b0, p, c, 16'h0);
    endtask

    // expectation applies to the outputs after the next rising edge
    task automatic st(input logic [6:0] e);
        @(negedge core_clk);
        st_q.push_back({9'h0, e});
        samp = 1'b1;
        @(negedge core_clk);
        samp = 1'b0;
    endtask

    task automatic rst();
        @(negedge core_clk);
        srst = 1'b1;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
    endtask

    function automatic logic [15:0] dflt(logic [15:0] s, logic [4:0] nu, logic [4:0] de);
        logic [31:0] t;
        t = (32'(s) * nu) / de;
        return (t > 32'hffff) ? 16'hffff : t[15:0];
    endfunction

    initial begin
        srst = 1'b1; clear_faults = 1'b0; samp = 1'b0; meas = '0; mv = '0;
        pgf = 2'b11; ramp = '0; on_req = 2'b11; bias = 2'b11; oth = '0;
        void'($urandom(32'hfb30));
        strap[0] = 16'h2000;
        strap[1] = 16'($urandom);
        rst();
        for (int p = 0; p < 2; p++) begin
            rd(p[0], `VFR_CMD_OV_LIMIT, dflt(strap[p], `VFR_OV_DEF_NUM, `VFR_OV_DEF_DEN));
            rd(p[0], `VFR_CMD_UV_LIMIT, dflt(strap[p], `VFR_UV_DEF_NUM, `VFR_UV_DEF_DEN));
            rd(p[0], `VFR_CMD_OV_RSP, 16'h0080);
            rd(p[0], `VFR_CMD_UV_RSP, 16'h0080);
        end
        st(7'b11_00_00_0);
        for (int p = 0; p < 2; p++) begin
            lo[p] = 16'($urandom);
            wr(p[0], `VFR_CMD_OV_LIMIT, lo[p]);
            wr(p[0], `VFR_CMD_UV_LIMIT, ~lo[p]);
            wr(p[0], `VFR_CMD_OV_RSP, {8'h5a, 7'h61, p[0]});
        end
        for (int p = 0; p < 2; p++) begin
            rd(p[0], `VFR_CMD_OV_LIMIT, lo[p]);
            rd(p[0], `VFR_CMD_UV_LIMIT, ~lo[p]);
            rd(p[0], `VFR_CMD_OV_RSP, {8'h00, 7'h61, p[0]});
        end
        rd(1'b0, 8'h42, 16'h0);
        // overvoltage with plain shutdown: equal is no fault, one above latches off
        rst();
        wr(1'b0, `VFR_CMD_OV_LIMIT, 16'h3000);
        meas[0] = 16'h3000; mv = 2'b01;
        repeat (3) @(negedge core_clk);
        st(7'b11_00_00_0);
        meas[0] = 16'h3001;
        repeat (2) @(negedge core_clk);
        st(7'b10_01_00_1);
        mv = 2'b00;
        repeat (20) @(negedge core_clk);
        st(7'b10_01_00_1);
        clear_faults = 1'b1;
        @(negedge core_clk);
        clear_faults = 1'b0;
        repeat (2) @(negedge core_clk);
        st(7'b10_00_00_0);
        repeat (100) @(negedge core_clk);
        st(7'b10_00_00_0);
        // undervoltage masked while not power good, ramping or disabled
        rst();
        vfr_host_model_i.set_uv_safe(1'b1, 16'h1800, 16'h1c00);
        meas[1] = 16'h1000; mv = 2'b10; pgf[1] = 1'b0;
        repeat (4) @(negedge core_clk);
        st(7'b11_00_00_0);
        pgf[1] = 1'b1; ramp[1] = 1'b1;
        repeat (4) @(negedge core_clk);
        st(7'b11_00_00_0);
        ramp[1] = 1'b0; on_req[1] = 1'b0;
        repeat (4) @(negedge core_clk);
        st(7'b11_00_00_0);
        on_req[1] = 1'b1;
        repeat (3) @(negedge core_clk);
        st(7'b01_00_10_1);
        mv = 2'b00;
        // continuous retry, shortest, random and longest delay
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 3'h0 : (i == 1) ? 3'($urandom_range(1, 6)) : 3'h7;
            rst();
            wr(1'b0, `VFR_CMD_OV_RSP, {8'h0, 5'h1f, d});
            wr(1'b0, `VFR_CMD_OV_LIMIT, 16'h3000);
            meas[0] = 16'h3001; mv = 2'b01;
            n = 0;
            while (n < 20 && rail_enable[0] !== 1'b0) begin
                @(posedge core_clk); #2; n++;
            end
            n = 0;
            while (n < 2000 && rail_enable[0] === 1'b0) begin
                @(posedge core_clk); #2; n++;
            end
            chk(16'(n), 16'((d + 1) * UNIT));
            n = 0;
            begin : per
                logic seen;
                seen = 1'b0;
                while (n < 2000 && !(seen && rail_enable[0] === 1'b1)) begin
                    @(posedge core_clk); #2; n++;
                    if (rail_enable[0] === 1'b0) seen = 1'b1;
                end
            end
            chk(16'(n), 16'((d + 1) * UNIT));
            // odd pass ends retries from an attempt, the others from the wait
            repeat ((i == 1) ? 1 : 2) @(negedge core_clk);
            on_req[0] = 1'b0; mv = 2'b00;
            repeat (3) @(negedge core_clk);
            st(7'b11_01_00_1);
            on_req[0] = 1'b1;
        end
        // retrying rail: another fault latches it, bias loss ends retries,
        // and a response with bit 7 clear only flags
        for (int i = 0; i < 3; i++) begin
            rst();
            wr(1'b0, `VFR_CMD_OV_RSP, (i == 2) ? 16'h003f : 16'h00f9);
            wr(1'b0, `VFR_CMD_OV_LIMIT, 16'h3000);
            meas[0] = 16'h3001;
            mv = 2'b01;
            repeat (3) @(negedge core_clk);
            oth[0] = (i == 0);
            bias[0] = (i != 1);
            mv = 2'b00;
            @(negedge core_clk);
            oth[0] = 1'b0;
            bias[0] = 1'b1;
            repeat (40) @(negedge core_clk);
            st((i == 0) ? 7'b10_01_00_1 : 7'b11_01_00_1);
        end
        repeat (3) @(negedge core_clk);
        conclude();
    end
endmodule
